// *** src/monitor_dev.sv ***
// device end: frame decode, register pages, result packets and id assignment
// Operation
// - register frames are 32 bits with five fields
// - fields: addr 31-27, dir 26, reg 25-20, data, crc
// - act only on good crc and matching address
// - registers paged; page zero after power-on
// - result packet 64 bits with fixed field layout
// - page zero results use one packet format
// - 12-bit crc 0xb41; bad-crc writes discarded
// - register replies carry freshly computed 12-bit crc
// - result packet carries 16-bit crc 0xc86c
// - host appends crc, checks reply crc
// - life counter increments per finished conversion
// - host tracks life counter per device
// - drained shift register returns zeros only
// - host treats all-zero packet as missed conversion
// - secondary data inverted, four leading zeros
// - host strips zeros and inverts secondary data
// - 5-bit ids, head programmed, followers incremented
// - id kept over soft reset
// - id zero after reset; broadcast never assigned
// - cells at 0x01-0x08 and 0x21-0x28
// - host confirms ids by register read
//
// Added by the designer: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
module monitor_dev
  import monitor_pkg::*;
(
  input  wire logic        clock_in,
  input  wire logic        rst_b_in,
  monitor_link_if.dev      link,
  input  wire logic [4:0]  chain_pos_in,
  input  wire logic        res_we_in,
  input  wire logic [3:0]  res_idx_in,
  input  wire logic [13:0] res_data_in,
  input  wire logic        conv_done_in,
  output logic      [4:0]  dev_id_out,
  output logic             page_out,
  output logic      [2:0]  life_out,
  output logic             frame_ok_out,
  output logic             frame_bad_out
);
  import monitor_pkg::*;

  typedef struct packed {
    logic             sck_s1;
    logic             sck_s2;
    logic             sck_s3;
    logic             cs_s1;
    logic             cs_s2;
    logic             cs_s3;
    logic             mosi_s1;
    logic             mosi_s2;
    logic [5:0]       nbits;
    logic [31:0]      rx;
    logic [63:0]      sh;
    logic [4:0]       id;
    logic             page;
    logic [2:0]       life;
    logic             fresh;
    logic             ok;
    logic             bad;
    logic [15:0][13:0] res;
  } dev_st_t;

  dev_st_t st_r;
  dev_st_t st_nxt;

  // decoded fields of the frame just received
  logic [4:0]  f_addr;
  logic        f_dir;
  logic [5:0]  f_reg;
  logic [7:0]  f_data;
  logic [11:0] f_crc;
  logic        sck_rise;
  logic        sck_fall;
  logic        cs_end;
  logic        cs_low;
  logic        crc_good;
  logic        addr_hit;
  logic        frame_ok;
  logic        is_result;
  logic [2:0]  ch_i;
  logic [2:0]  ch_j;
  logic [5:0]  chan2;
  logic [13:0] data1;
  logic [13:0] data2;
  logic [47:0] pkt_hi;
  logic [63:0] pkt;
  logic [7:0]  rd_byte;
  logic [19:0] rep_hdr;
  logic [4:0]  new_id;

  // field split of the received frame
  assign f_addr = st_r.rx[31:27];
  assign f_dir  = st_r.rx[26];
  assign f_reg  = st_r.rx[25:20];
  assign f_data = st_r.rx[19:12];
  assign f_crc  = st_r.rx[11:0];

  // link edges seen through the second and third sync stages only
  assign sck_rise = st_r.sck_s2 & ~st_r.sck_s3;
  assign sck_fall = ~st_r.sck_s2 & st_r.sck_s3;
  assign cs_end   = st_r.cs_s2 & ~st_r.cs_s3;
  assign cs_low   = ~st_r.cs_s2;

  // frame acceptance: exact length, crc and address
  assign crc_good = (crc12(st_r.rx[31:12]) == f_crc);
  assign addr_hit = (f_addr == st_r.id) || (f_addr == BCAST_ADDR);
  assign frame_ok = (st_r.nbits == 6'(FRAME_BITS)) && crc_good && addr_hit;

  // result channels live on the two cell address windows
  assign is_result = ((f_reg >= PRIM_FIRST) && (f_reg <= PRIM_LAST))
                  || ((f_reg >= SEC_FIRST) && (f_reg <= SEC_LAST));

  // channel pairing: requested channel and its neighbour, wrapping 8 to 1
  assign ch_i  = 3'(f_reg[3:0] - 4'h1);
  assign ch_j  = 3'(ch_i + 3'h1);
  assign chan2 = {f_reg[5:4], 4'({1'b0, ch_j} + 4'h1)};

  // secondary results are 10 bits; invert and pad to hide masquerade
  always_comb begin
    if (f_reg[5]) begin
      data1 = {4'h0, ~st_r.res[{1'b1, ch_i}][9:0]};
      data2 = {4'h0, ~st_r.res[{1'b1, ch_j}][9:0]};
    end else begin
      data1 = st_r.res[{1'b0, ch_i}];
      data2 = st_r.res[{1'b0, ch_j}];
    end
  end

  // result packet, same layout for both paths
  assign pkt_hi = {f_reg, st_r.life, chan2, data1, st_r.id, data2};
  assign pkt    = {pkt_hi, crc16(pkt_hi)};

  // register read reply contents
  always_comb begin
    unique case (f_reg)
      REG_PAGE:    rd_byte = {7'h00, st_r.page};
      REG_DEVADDR: rd_byte = {3'h0, st_r.id};
      REG_LIFE:    rd_byte = {5'h00, st_r.life};
      default:     rd_byte = 8'h00;
    endcase
  end
  assign rep_hdr = {st_r.id, DIR_RD, f_reg, rd_byte};

  // head takes the programmed id, followers add their chain position
  assign new_id = 5'(f_data[4:0] + chain_pos_in);

  // next-state logic
  always_comb begin
    st_nxt         = st_r;
    st_nxt.sck_s1  = link.sclk;
    st_nxt.sck_s2  = st_r.sck_s1;
    st_nxt.sck_s3  = st_r.sck_s2;
    st_nxt.cs_s1   = link.cs_b;
    st_nxt.cs_s2   = st_r.cs_s1;
    st_nxt.cs_s3   = st_r.cs_s2;
    st_nxt.mosi_s1 = link.mosi;
    st_nxt.mosi_s2 = st_r.mosi_s1;
    st_nxt.ok      = 1'b0;
    st_nxt.bad     = 1'b0;

    // result capture from the measurement side
    if (res_we_in) begin
      st_nxt.res[res_idx_in] = res_data_in;
    end
    // a finished conversion bumps the counter and arms the next readback
    if (conv_done_in) begin
      st_nxt.life = 3'(st_r.life + 3'h1);
    end
    st_nxt.fresh = st_r.fresh | conv_done_in;

    // sample on rising, advance on falling; the bit count saturates
    if (cs_low && sck_rise) begin
      st_nxt.rx = {st_r.rx[30:0], st_r.mosi_s2};
      if (st_r.nbits != 6'h3f) begin
        st_nxt.nbits = 6'(st_r.nbits + 6'h01);
      end
    end
    // zero fill behind the outgoing bits; the last fall arrives with the select
    // release, so the frame counts as open while the delayed stage is still low
    if (!st_r.cs_s3 && sck_fall) begin
      st_nxt.sh = {st_r.sh[62:0], 1'b0};
    end

    // frame end: decode and act
    if (cs_end) begin
      st_nxt.nbits = 6'h00;
      st_nxt.ok    = frame_ok;
      st_nxt.bad   = ~frame_ok;
      if (frame_ok) begin
        if (f_dir == DIR_WR) begin
          unique case (f_reg)
            REG_PAGE: begin
              st_nxt.page = f_data[0];
            end
            REG_DEVADDR: begin
              // config page only; never take the broadcast value
              if (st_r.page == PAGE_CFG && new_id != BCAST_ADDR) begin
                st_nxt.id = new_id;
              end
            end
            REG_SWRST: begin
              // soft reset clears page, fresh flag and shift register but keeps the id and stored results
              st_nxt.page  = PAGE_RST;
              st_nxt.fresh = conv_done_in;
              st_nxt.sh    = '0;
            end
            default: begin
              // other writes leave the outgoing shift register running
            end
          endcase
        end else if (st_r.page == PAGE_RST && is_result) begin
          // stale results read back as all zeros, crc field included
          st_nxt.sh    = st_r.fresh ? pkt : '0;
          st_nxt.fresh = conv_done_in;
        end else begin
          st_nxt.sh = {rep_hdr, crc12(rep_hdr), 32'h0};
        end
      end
    end
  end

  // state register; pin reset drops id to zero and page to zero
  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      st_r <= '0;
      // select sync starts deselected so no false frame end follows reset
      st_r.cs_s1 <= 1'b1;
      st_r.cs_s2 <= 1'b1;
      st_r.cs_s3 <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign link.miso     = st_r.sh[63];
  assign dev_id_out    = st_r.id;
  assign page_out      = st_r.page;
  assign life_out      = st_r.life;
  assign frame_ok_out  = st_r.ok;
  assign frame_bad_out = st_r.bad;
endmodule : monitor_dev

// *** src/monitor_pkg.sv ***
// shared constants, crc functions and link timing for the monitor frame protocol
package monitor_pkg;
  // frame geometry
  localparam int          FRAME_BITS   = 32;
  localparam int          PKT_BITS     = 64;
  localparam logic        DIR_WR       = 1'b0;
  localparam logic        DIR_RD       = 1'b1;
  // addressing
  localparam logic [4:0]  BCAST_ADDR   = 5'h1f;
  localparam logic [4:0]  DEV_ADDR_RST = 5'h00;
  localparam logic        PAGE_RST     = 1'b0;
  localparam logic        PAGE_CFG     = 1'b1;
  // device register addresses
  localparam logic [5:0]  REG_PAGE     = 6'h3f;
  localparam logic [5:0]  REG_DEVADDR  = 6'h3e;
  localparam logic [5:0]  REG_SWRST    = 6'h3d;
  localparam logic [5:0]  REG_LIFE     = 6'h3c;
  localparam logic [5:0]  PRIM_FIRST   = 6'h01;
  localparam logic [5:0]  PRIM_LAST    = 6'h08;
  localparam logic [5:0]  SEC_FIRST    = 6'h21;
  localparam logic [5:0]  SEC_LAST     = 6'h28;
  // crc polynomials
  localparam logic [11:0] CRC12_POLY   = 12'hb41;
  localparam logic [15:0] CRC16_POLY   = 16'hc86c;
  // link timing: the host divides its clock down to the link clock
  localparam int          CLK_NS       = 40;
  localparam int          LINK_CLK_NS  = 320;
  localparam int          HALF_CYC     = LINK_CLK_NS / CLK_NS / 2;
  // host controller register offsets
  localparam logic [4:0]  H_CMD        = 5'h00;
  localparam logic [4:0]  H_STATUS     = 5'h04;
  localparam logic [4:0]  H_RXHI       = 5'h08;
  localparam logic [4:0]  H_RXLO       = 5'h0c;
  localparam logic [4:0]  H_DATA       = 5'h10;

  // 12-bit crc, msb first, zero start, over header bits 31..12
  function automatic logic [11:0] crc12(input logic [19:0] d);
    logic [11:0] c;
    logic        fb;
    c = 12'h000;
    for (int i = 19; i >= 0; i--) begin
      fb = c[11] ^ d[i];
      c  = {c[10:0], 1'b0};
      if (fb) begin
        c = c ^ CRC12_POLY;
      end
    end
    return c;
  endfunction : crc12

  // 16-bit crc, msb first, zero start, over packet bits 63..16
  function automatic logic [15:0] crc16(input logic [47:0] d);
    logic [15:0] c;
    logic        fb;
    c = 16'h0000;
    for (int i = 47; i >= 0; i--) begin
      fb = c[15] ^ d[i];
      c  = {c[14:0], 1'b0};
      if (fb) begin
        c = c ^ CRC16_POLY;
      end
    end
    return c;
  endfunction : crc16
endpackage : monitor_pkg

// *** src/monitor_link_if.sv ***
// serial link between host controller and monitor device
`timescale 1ns/1ps
interface monitor_link_if;
  logic sclk;     // link clock, made by the host
  logic cs_b;     // frame select, active low
  logic mosi;     // host to device data
  logic miso;     // device to host data

  modport dev (
    input  sclk,
    input  cs_b,
    input  mosi,
    output miso
  );

  modport host (
    output sclk,
    output cs_b,
    output mosi,
    input  miso
  );
endinterface : monitor_link_if

// *** src/monitor_host.sv ***
// host end: link clock divider, frame sender with crc, reply checker
`timescale 1ns/1ps
module monitor_host
  import monitor_pkg::*;
(
  input  wire logic        clock_in,
  input  wire logic        rst_b_in,
  monitor_link_if.host     link,
  input  wire logic [4:0]  addr_in,
  input  wire logic [31:0] wdata_in,
  input  wire logic        wr_in,
  input  wire logic        rd_in,
  output logic      [31:0] rdata_out
);
  import monitor_pkg::*;

  typedef enum logic [1:0] {
    S_IDLE = 2'b00,
    S_LOW  = 2'b01,
    S_HIGH = 2'b10,
    S_GAP  = 2'b11
  } hst_state_t;

  typedef struct packed {
    hst_state_t       state;
    logic [2:0]       div;
    logic [5:0]       nbit;
    logic             long_rd;
    logic             second;
    logic [31:0]      tx;
    logic [63:0]      rx;
    logic             sclk;
    logic             cs_b;
    logic             mosi;
    logic             miso_s1;
    logic             miso_s2;
    logic             crc_err;
    logic             zero_pkt;
    logic             life_err;
    logic [31:0]      seen;
    logic [31:0][2:0] life;
    logic [31:0]      rdata;
  } hst_st_t;

  hst_st_t     st_r;
  hst_st_t     st_nxt;
  logic [4:0]  pdev;
  logic [13:0] dec1;
  logic [13:0] dec2;

  // secondary fields come back inverted behind four zeros
  assign pdev = st_r.rx[34:30];
  assign dec1 = st_r.rx[63] ? {4'h0, ~st_r.rx[44:35]} : st_r.rx[48:35];
  assign dec2 = st_r.rx[54] ? {4'h0, ~st_r.rx[25:16]} : st_r.rx[29:16];

  always_comb begin
    st_nxt         = st_r;
    st_nxt.miso_s1 = link.miso;
    st_nxt.miso_s2 = st_r.miso_s1;
    st_nxt.rdata   = 32'h0;

    // register reads; reading status clears the sticky flags
    if (rd_in) begin
      unique case (addr_in)
        H_STATUS: st_nxt.rdata = {28'h0, st_r.life_err, st_r.zero_pkt, st_r.crc_err,
                                  st_r.state != S_IDLE};
        H_RXHI:   st_nxt.rdata = st_r.rx[63:32];
        H_RXLO:   st_nxt.rdata = st_r.rx[31:0];
        H_DATA:   st_nxt.rdata = {2'b00, dec1, 2'b00, dec2};
        default:  st_nxt.rdata = 32'h0;
      endcase
      if (addr_in == H_STATUS) begin
        st_nxt.crc_err  = 1'b0;
        st_nxt.zero_pkt = 1'b0;
        st_nxt.life_err = 1'b0;
      end
    end

    unique case (st_r.state)
      S_IDLE: begin
        // commands while busy are dropped; header gets its crc here
        if (wr_in && addr_in == H_CMD) begin
          st_nxt.tx      = {wdata_in[19:0], crc12(wdata_in[19:0])};
          st_nxt.mosi    = wdata_in[19];
          st_nxt.long_rd = wdata_in[20];
          st_nxt.second  = 1'b0;
          st_nxt.cs_b    = 1'b0;
          st_nxt.nbit    = 6'h00;
          st_nxt.div     = 3'h0;
          st_nxt.state   = S_LOW;
        end
      end
      S_LOW: begin
        st_nxt.div = 3'(st_r.div + 3'h1);
        if (st_r.div == 3'(HALF_CYC - 1)) begin
          st_nxt.div   = 3'h0;
          st_nxt.sclk  = 1'b1;
          st_nxt.state = S_HIGH;
        end
      end
      S_HIGH: begin
        // sample late in the high half, leaving time for the device to settle
        st_nxt.div = 3'(st_r.div + 3'h1);
        if (st_r.div == 3'(HALF_CYC - 1)) begin
          st_nxt.div   = 3'h0;
          st_nxt.sclk  = 1'b0;
          st_nxt.rx    = {st_r.rx[62:0], st_r.miso_s2};
          st_nxt.tx    = {st_r.tx[30:0], 1'b0};
          st_nxt.mosi  = st_r.tx[30];
          st_nxt.nbit  = 6'(st_r.nbit + 6'h01);
          st_nxt.state = S_LOW;
          if (st_r.nbit == 6'(FRAME_BITS - 1)) begin
            st_nxt.cs_b  = 1'b1;
            st_nxt.state = S_GAP;
          end
        end
      end
      S_GAP: begin
        st_nxt.div = 3'(st_r.div + 3'h1);
        if (st_r.div == 3'(HALF_CYC - 1)) begin
          st_nxt.div = 3'h0;
          if (st_r.long_rd && !st_r.second) begin
            // filler frame clocks out the second half of the packet
            st_nxt.second = 1'b1;
            st_nxt.tx     = 32'h0;
            st_nxt.mosi   = 1'b0;
            st_nxt.cs_b   = 1'b0;
            st_nxt.nbit   = 6'h00;
            st_nxt.state  = S_LOW;
          end else begin
            st_nxt.state = S_IDLE;
            if (st_r.long_rd) begin
              if (st_r.rx == 64'h0) begin
                st_nxt.zero_pkt = 1'b1;
              end else if (crc16(st_r.rx[63:16]) != st_r.rx[15:0]) begin
                st_nxt.crc_err = 1'b1;
              end else begin
                // expected step is one conversion per readback
                if (st_r.seen[pdev] && st_r.rx[57:55] != 3'(st_r.life[pdev] + 3'h1)) begin
                  st_nxt.life_err = 1'b1;
                end
                st_nxt.seen[pdev] = 1'b1;
                st_nxt.life[pdev] = st_r.rx[57:55];
              end
            end else if (st_r.rx[31:0] != 32'h0
                         && crc12(st_r.rx[31:12]) != st_r.rx[11:0]) begin
              st_nxt.crc_err = 1'b1;
            end
          end
        end
      end
    endcase
  end

  // state register; link idles deselected with clock low
  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      st_r      <= '0;
      st_r.cs_b <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign link.sclk = st_r.sclk;
  assign link.cs_b = st_r.cs_b;
  assign link.mosi = st_r.mosi;
  assign rdata_out = st_r.rdata;
endmodule : monitor_host

// *** testbench/monitor_link_properties.sv ***
// concurrent checks on the serial link between host and device ends
`timescale 1ns/1ps
module monitor_link_properties (
  input wire logic clock_in,
  input wire logic rst_b_in,
  input wire logic sclk,
  input wire logic cs_b,
  input wire logic mosi,
  input wire logic miso
);
  logic [5:0] rise_cnt_r;

  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (!rst_b_in);

  // link clock rises seen inside the open frame; cleared while deselected
  always_ff @(posedge clock_in) begin
    if (!rst_b_in || cs_b) begin
      rise_cnt_r <= 6'h00;
    end else if ($rose(sclk)) begin
      rise_cnt_r <= rise_cnt_r + 6'h01;
    end
  end

  chk_frame_length: assert property ($rose(cs_b) |-> rise_cnt_r == 6'h20)
    else $error("frame closed without 32 link clock rises");
  chk_frame_span: assert property ($fell(cs_b) |-> ##[250:262] $rose(cs_b))
    else $error("frame select low for the wrong span");
  chk_sclk_idle: assert property (cs_b |-> !sclk)
    else $error("link clock moves outside a frame");
  chk_sclk_high: assert property ($rose(sclk) |-> sclk [*4] ##1 !sclk)
    else $error("link clock high phase not four cycles");
  chk_frame_start: assert property ($fell(cs_b) |-> !sclk [*4] ##1 sclk)
    else $error("first link clock rise misplaced");
  chk_mosi_steady: assert property (sclk && $past(sclk) |-> $stable(mosi))
    else $error("host data moved while link clock high");
  chk_miso_steady: assert property (sclk && $past(sclk) |-> $stable(miso))
    else $error("device data moved while link clock high");
  chk_frame_gap: assert property ($rose(cs_b) |-> cs_b [*4])
    else $error("frames closer than four cycles");
  chk_reset_idle: assert property ($rose(rst_b_in) |-> cs_b && !sclk && !miso)
    else $error("link not idle when reset ends");

  cov_frame_done: cover property ($rose(cs_b) && rise_cnt_r == 6'h20);
  cov_long_read: cover property ($rose(cs_b) ##[4:10] $fell(cs_b));
  cov_reply_bit: cover property (!cs_b && miso);
endmodule : monitor_link_properties

// *** testbench/test_monitor_packet_protocol.sv ***
// self-checking bench: host and device ends joined, plus a hand-driven device
`timescale 1ns/1ps
`define CHK(a, e) \
  begin checks_done++; if ((a) !== (e)) begin n_mismatch++; \
  $display("[FAIL] t=%0t got %0h exp %0h", $time, (a), (e)); end end
module test_monitor_packet_protocol;
  import monitor_pkg::*;
  logic        clock_in, rst_b_in, res_we_in, conv_done_in, wr_in, rd_in;
  logic [4:0]  chain_pos_in, addr_in, dev_id, id_m;
  logic [3:0]  res_idx_in;
  logic [13:0] res_data_in;
  logic [13:0] res_m [16];
  logic [31:0] wdata_in, rdata, st, hi, lo, seed;
  logic [2:0]  life, life_m;
  logic [19:0] h20;
  logic [11:0] c12;
  logic        page, page2, bad2, ok2;
  int          n_mismatch, checks_done, nbad2, nok2;

  monitor_link_if link ();
  monitor_link_if link2 ();
  monitor_dev u_monitor_dev (.clock_in(clock_in), .rst_b_in(rst_b_in), .link(link.dev),
    .chain_pos_in(chain_pos_in), .res_we_in(res_we_in), .res_idx_in(res_idx_in),
    .res_data_in(res_data_in), .conv_done_in(conv_done_in), .dev_id_out(dev_id),
    .page_out(page), .life_out(life), .frame_ok_out(), .frame_bad_out());
  monitor_dev u_monitor_dev_b (.clock_in(clock_in), .rst_b_in(rst_b_in), .link(link2.dev),
    .chain_pos_in(chain_pos_in), .res_we_in(res_we_in), .res_idx_in(res_idx_in),
    .res_data_in(res_data_in), .conv_done_in(conv_done_in), .dev_id_out(),
    .page_out(page2), .life_out(), .frame_ok_out(ok2), .frame_bad_out(bad2));
  monitor_host u_monitor_host (.clock_in(clock_in), .rst_b_in(rst_b_in), .link(link.host),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata));
  monitor_link_properties props (.clock_in(clock_in), .rst_b_in(rst_b_in),
    .sclk(link.sclk), .cs_b(link.cs_b), .mosi(link.mosi), .miso(link.miso));

  // clock and accepted and rejected frame counters of the hand-driven device
  initial begin
    clock_in = 1'b0;
    forever #20 clock_in = ~clock_in;
  end
  always @(posedge clock_in) begin
    if (bad2 === 1'b1) nbad2++;
    if (ok2 === 1'b1) nok2++;
  end

  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : final_report

  // crc reference, msb first from zero, kept apart from the package copy
  function automatic logic [15:0] crc_ref(input logic [47:0] d, input int nb, input int w,
                                          input logic [15:0] p);
    logic [15:0] c;
    logic        fb;
    c = 16'h0000;
    for (int i = nb - 1; i >= 0; i--) begin
      fb = c[w-1] ^ d[i];
      c = ((c << 1) & 16'((1 << w) - 1)) ^ (fb ? p : 16'h0000);
    end
    return c;
  endfunction : crc_ref

  // data field of a channel; inv picks the wire form of secondary results
  function automatic logic [13:0] fld(input logic [5:0] r, input logic inv);
    logic [3:0] s;
    s = {r[5], r[2:0] - 3'h1};
    if (!r[5]) return res_m[s];
    return inv ? {4'h0, ~res_m[s][9:0]} : {4'h0, res_m[s][9:0]};
  endfunction : fld

  // register port: strobes held one cycle, a free cycle after each
  task automatic bus_wr(input logic [4:0] a, input logic [31:0] d);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge clock_in);
    wr_in <= 1'b0;
    @(posedge clock_in);
  endtask : bus_wr

  task automatic bus_rd(input logic [4:0] a, output logic [31:0] d);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clock_in);
    rd_in <= 1'b0;
    @(negedge clock_in);
    d = rdata;
    @(posedge clock_in);
  endtask : bus_rd

  // one command; status kept from the poll that sees the end of busy
  task automatic op(input logic [31:0] cmd, output logic [31:0] s);
    bus_wr(H_CMD, cmd);
    s = 32'h1;
    for (int n = 0; n < 500 && s[0] !== 1'b0; n++) bus_rd(H_STATUS, s);
    `CHK(s[0], 1'b0)
  endtask : op

  // read command, then two zero filler frames bring the reply home
  task automatic rd_res(input logic [5:0] r, output logic [31:0] h, l, s);
    op({12'h000, id_m, DIR_RD, r, 8'h00}, s);
    op(32'h0010_0000, s);
    bus_rd(H_RXHI, h);
    bus_rd(H_RXLO, l);
  endtask : rd_res

  task automatic load_res(input int nconv);
    for (int i = 0; i < 16; i++) begin
      res_m[i] = 14'($urandom);
      res_idx_in <= 4'(i);
      res_data_in <= res_m[i];
      res_we_in <= 1'b1;
      @(posedge clock_in);
    end
    res_we_in <= 1'b0;
    for (int i = 0; i < nconv; i++) begin
      conv_done_in <= 1'b1;
      @(posedge clock_in);
      conv_done_in <= 1'b0;
      @(posedge clock_in);
    end
    life_m = life_m + 3'(nconv);
  endtask : load_res

  task automatic check_res(input logic [5:0] r, input logic [3:0] exp_st);
    logic [5:0]  r2;
    logic [47:0] body;
    logic [31:0] dv;
    r2 = (r[2:0] == 3'h0) ? r - 6'h07 : r + 6'h01;
    body = {r, life_m, r2, fld(r, 1'b1), id_m, fld(r2, 1'b1)};
    rd_res(r, hi, lo, st);
    `CHK({hi, lo}, {body, crc_ref(body, 48, 16, CRC16_POLY)})
    `CHK(st[3:0], exp_st)
    bus_rd(H_DATA, dv);
    `CHK(dv, {2'b00, fld(r, 1'b0), 2'b00, fld(r2, 1'b0)})
  endtask : check_res

  // hand-driven frame to the second device, link clock still outside it
  task automatic send2(input logic [31:0] f);
    link2.cs_b <= 1'b0;
    for (int i = 31; i >= 0; i--) begin
      link2.mosi <= f[i];
      repeat (4) @(posedge clock_in);
      link2.sclk <= 1'b1;
      repeat (4) @(posedge clock_in);
      link2.sclk <= 1'b0;
    end
    repeat (4) @(posedge clock_in);
    link2.cs_b <= 1'b1;
    link2.mosi <= ~f[0];
    repeat (12) @(posedge clock_in);
  endtask : send2

  // a hang counts as a mismatch
  initial begin
    repeat (80000) @(posedge clock_in);
    n_mismatch++;
    final_report();
  end

  initial begin
    seed = $urandom(32'h9212f667);
    {rst_b_in, res_we_in, conv_done_in, wr_in, rd_in} = 5'h00;
    {addr_in, wdata_in, res_idx_in, res_data_in, life_m} = '0;
    {link2.sclk, link2.cs_b, link2.mosi} = 3'b010;
    chain_pos_in = 5'($urandom % 16);
    repeat (16) @(posedge clock_in);
    rst_b_in <= 1'b1;
    @(posedge clock_in);
    `CHK(dev_id, DEV_ADDR_RST)
    `CHK(page, PAGE_RST)
    op({12'h000, BCAST_ADDR, DIR_WR, REG_PAGE, 8'h01}, st);
    `CHK(page, PAGE_CFG)
    id_m = 5'h05 + chain_pos_in;
    op({12'h000, BCAST_ADDR, DIR_WR, REG_DEVADDR, 8'h05}, st);
    `CHK(dev_id, id_m)
    op({12'h000, id_m, DIR_WR, REG_DEVADDR, 3'h0, 5'h1f - chain_pos_in}, st);
    `CHK(dev_id, id_m)
    rd_res(REG_PAGE, hi, lo, st);
    h20 = {id_m, DIR_RD, REG_PAGE, 8'h01};
    c12 = 12'(crc_ref(48'(h20), 20, 12, 16'(CRC12_POLY)));
    `CHK(hi, {h20, c12})
    `CHK(lo, 32'h0)
    op({12'h000, id_m ^ 5'h01, DIR_WR, REG_PAGE, 8'h00}, st);
    `CHK(page, PAGE_CFG)
    op({12'h000, id_m, DIR_WR, REG_PAGE, 8'h00}, st);
    `CHK(page, PAGE_RST)
    // every primary and secondary channel, life counter wrapping twice
    for (int k = 0; k < 16; k++) begin
      load_res(1);
      `CHK(life, life_m)
      check_res(k < 8 ? 6'(k + 1) : 6'(k + 25), 4'h0);
    end
    rd_res(PRIM_FIRST, hi, lo, st);
    `CHK({hi, lo}, 64'h0)
    `CHK(st[3:0], 4'h4)
    load_res(2);
    check_res(PRIM_LAST, 4'h8);
    load_res(1);
    op({12'h000, id_m, DIR_WR, REG_SWRST, 8'h00}, st);
    `CHK(dev_id, id_m)
    rd_res(SEC_FIRST, hi, lo, st);
    `CHK({hi, lo}, 64'h0)
    // life counter register survives the soft reset and replies with fresh crc
    rd_res(REG_LIFE, hi, lo, st);
    h20 = {id_m, DIR_RD, REG_LIFE, 5'h00, life_m};
    c12 = 12'(crc_ref(48'(h20), 20, 12, 16'(CRC12_POLY)));
    `CHK(hi, {h20, c12})
    // corrupted check bits are refused, the same frame intact is taken
    h20 = {BCAST_ADDR, DIR_WR, REG_PAGE, 8'h01};
    c12 = 12'(crc_ref(48'(h20), 20, 12, 16'(CRC12_POLY)));
    send2({h20, c12 ^ 12'h001});
    `CHK(nbad2, 1)
    `CHK(nok2, 0)
    `CHK(page2, PAGE_RST)
    send2({h20, c12});
    `CHK(nok2, 1)
    `CHK(page2, PAGE_CFG)
    rst_b_in <= 1'b0;
    repeat (2) @(posedge clock_in);
    rst_b_in <= 1'b1;
    @(posedge clock_in);
    `CHK(dev_id, DEV_ADDR_RST)
    final_report();
  end
endmodule : test_monitor_packet_protocol
